// File: rtl/fct_pkg.sv
package fct_pkg;
   localparam int N_CTR = 5;
   localparam int N_ALARM = 2;
   localparam int BCD_DIGITS = 4;
   // clock and oscillator rates
   localparam int CLK_HZ = 40_000_000;
   localparam int OSC_HZ = 8_000_000;
   localparam logic [2:0] PRE_LAST = 3'(CLK_HZ / OSC_HZ - 1);
   // host strobe stretch
   localparam int STRETCH_NS = 400;
   localparam int STRETCH_CYC = (STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [4:0] STRETCH_LOAD = 5'(STRETCH_CYC - 3);
   // card registers, selected by the two low word-address bits
   localparam logic [1:0] REG_DATA = 2'h0;
   localparam logic [1:0] REG_CTRL = 2'h1;
   localparam logic [1:0] REG_DIO = 2'h2;
   localparam logic [1:0] REG_OPT = 2'h3;
   // element codes behind the data register
   localparam logic [2:0] EL_MODE = 3'h0;
   localparam logic [2:0] EL_LOAD = 3'h1;
   localparam logic [2:0] EL_HOLD = 3'h2;
   localparam logic [2:0] EL_ALARM = 3'h3;
   localparam logic [2:0] EL_COUNT = 3'h4;
   // control register fields
   localparam int CTL_ARM_LSB = 8;
   localparam int CTL_DISARM_LSB = 13;
   localparam int CTL_CAPT_LSB = 18;
   localparam int CTL_LOAD_LSB = 23;
   localparam int CTL_SETPTR_BIT = 30;
   localparam int CTL_CLR_BIT = 31;
   // count limits
   localparam logic [15:0] BIN_MAX = 16'hFFFF;
   localparam logic [15:0] BCD_MAX = 16'h9999;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [15:0] TOD_MAX_MMSS = 16'h5959;
   localparam logic [15:0] TOD_MAX_HH = 16'h0023;
   localparam logic [7:0] TOD_SEC_MAX = 8'h59;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [6:0] TOD_DIV50 = 7'h32;
   localparam logic [6:0] TOD_DIV60 = 7'h3C;
   localparam logic [6:0] TOD_DIV100 = 7'h64;
   localparam logic [1:0] TOD_HZ50 = 2'h0;
   localparam logic [1:0] TOD_HZ60 = 2'h1;
   localparam logic [1:0] TB_OFF = 2'h3;
   localparam logic [2:0] IRQ_LINES = 3'h6;
   localparam logic [5:0] IRQ_FIRST = 6'h01;

   typedef struct packed {
      logic reloadEn;
      logic [1:0] todHz;
      logic todEn;
      logic outEn;
      logic altReload;
      logic bcd;
      logic down;
      logic [2:0] gateSel;
      logic srcInv;
      logic spare;
      logic [2:0] srcSel;
   } fct_mode_t;

   typedef struct packed {
      logic doutDrive;
      logic [2:0] irqSel;
      logic stretch;
      logic [4:0] syncFall;
      logic [4:0] syncEn;
      logic [1:0] tbSel;
   } fct_opt_t;

   localparam fct_opt_t OPT_RST = '0;
   localparam fct_mode_t MODE_RST = '0;

   // one BCD count step, up or down, wrapping at 9999 / 0000
   function automatic logic [15:0] fctBcdStep(input logic [15:0] v,
                                              input logic dn);
      logic [15:0] r;
      logic cy;
      r = v;
      cy = 1'b1;
      for (int k = 0; k < BCD_DIGITS; k++) begin
         if (cy) begin
            if (dn) begin
               cy = (r[4*k +: 4] == 4'h0);
               r[4*k +: 4] = cy ? BCD_DIGIT_MAX : r[4*k +: 4] - 4'h1;
            end else begin
               cy = (r[4*k +: 4] == BCD_DIGIT_MAX);
               r[4*k +: 4] = cy ? 4'h0 : r[4*k +: 4] + 4'h1;
            end
         end
      end
      return r;
   endfunction : fctBcdStep
endpackage : fct_pkg

// File: rtl/fct_card.sv
module fct_card (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] baseSwClosed,
   input wire logic [4:0] srcPin,
   input wire logic [4:0] gatePin,
   input wire logic lineHz,
   input wire logic [7:0] din,
   input wire logic dinEn,
   input wire logic irqIn,
   input wire logic intDisable,
   output wire [4:0] cntOut,
   output wire [4:0] cntOutOe,
   output logic [7:0] dout,
   output logic doutOe,
   output logic [5:0] irqLine
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   fct_pkg::fct_opt_t opt_q;
   logic [5:0] ptr_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic [4:0] waitCnt_q, strobeCyc_q;
   logic [2:0] preCnt_q, tbDiv_q;
   logic tbLvl_q;
   logic [7:0] inPort_q, dout_q;
   logic doutOe_q;
   logic irqIn_q, irqPend_q;
   logic [5:0] irqLine_q;
   logic [1:0] alarmFlag_q;
   wire [4:0][15:0] cntW, loadW, holdW, modeW, alarmW;
   wire [4:0] tcW, armedW, outLvlW;
   wire [1:0] alarmHitW;

   // timebase: 8 MHz tick from the 40 MHz clock, then three halving stages
   wire preTick = (preCnt_q == fct_pkg::PRE_LAST);
   wire tbOn = (opt_q.tbSel != fct_pkg::TB_OFF);
   wire tbSelLvl = tbOn & tbDiv_q[opt_q.tbSel];
   wire tbRise = tbSelLvl & ~tbLvl_q;
   wire tbFall = ~tbSelLvl & tbLvl_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         preCnt_q <= 3'h0;
         tbDiv_q <= 3'h0;
         tbLvl_q <= 1'b0;
      end else begin
         preCnt_q <= preTick ? 3'h0 : preCnt_q + 3'h1;
         tbDiv_q <= preTick ? tbDiv_q + 3'h1 : tbDiv_q;
         tbLvl_q <= tbSelLvl;
      end
   end

   // address window: word address bits 9..2 against the switches
   wire [7:0] winAddr = paddr[11:4];
   wire [1:0] regSel = paddr[3:2];
   wire addrHit = (winAddr == ~baseSwClosed) &&
                  (winAddr[7:6] != 2'h0);
   wire setupPh = psel & ~penable;
   wire accPh = psel & penable;
   wire xferEnd = accPh & pready_q;
   wire wrEn = xferEnd & pwrite & addrHit;
   wire wrData = wrEn & (regSel == fct_pkg::REG_DATA);
   wire wrCtrl = wrEn & (regSel == fct_pkg::REG_CTRL);
   wire wrDio = wrEn & (regSel == fct_pkg::REG_DIO);
   wire wrOpt = wrEn & (regSel == fct_pkg::REG_OPT);

   // control register command fields
   wire [4:0] armSet = wrCtrl ? pwdata[fct_pkg::CTL_ARM_LSB +: 5] : 5'h00;
   wire [4:0] armClr = wrCtrl ? pwdata[fct_pkg::CTL_DISARM_LSB +: 5] : 5'h00;
   wire [4:0] captNow = wrCtrl ? pwdata[fct_pkg::CTL_CAPT_LSB +: 5] : 5'h00;
   wire [4:0] loadNow = wrCtrl ? pwdata[fct_pkg::CTL_LOAD_LSB +: 5] : 5'h00;
   wire clrFlags = wrCtrl & pwdata[fct_pkg::CTL_CLR_BIT];
   wire setPtr = wrCtrl & pwdata[fct_pkg::CTL_SETPTR_BIT];

   // indirect element read through the pointer
   wire [2:0] ptrCtr = ptr_q[2:0];
   wire [2:0] ptrEl = ptr_q[5:3];
   wire ptrOk = (ptrCtr < 3'(fct_pkg::N_CTR));
   wire [15:0] elemRd =
      !ptrOk ? 16'h0000 :
      (ptrEl == fct_pkg::EL_MODE) ? modeW[ptrCtr] :
      (ptrEl == fct_pkg::EL_LOAD) ? loadW[ptrCtr] :
      (ptrEl == fct_pkg::EL_HOLD) ? holdW[ptrCtr] :
      (ptrEl == fct_pkg::EL_ALARM) ? alarmW[ptrCtr] :
      (ptrEl == fct_pkg::EL_COUNT) ? cntW[ptrCtr] : 16'h0000;
   wire [31:0] statusRd = {irqPend_q, 5'h00, alarmFlag_q, 3'h0, outLvlW,
                           3'h0, armedW, 2'h0, ptr_q};
   wire [31:0] rdMux =
      (regSel == fct_pkg::REG_DATA) ? {16'h0000, elemRd} :
      (regSel == fct_pkg::REG_CTRL) ? statusRd :
      (regSel == fct_pkg::REG_DIO) ? {16'h0000, inPort_q, dout_q} :
      {15'h0000, opt_q};

   // bus answer: one wait state, or a stretched strobe when enabled
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt_q <= 5'h00;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (setupPh) begin
         waitCnt_q <= opt_q.stretch ? fct_pkg::STRETCH_LOAD : 5'h00;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (accPh && !pready_q) begin
         if (waitCnt_q == 5'h00) begin
            pready_q <= 1'b1;
            prdata_q <= addrHit ? rdMux : 32'h0000_0000;
            pslverr_q <= ~addrHit;
         end else begin
            waitCnt_q <= waitCnt_q - 5'h01;
         end
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // helper count of strobe cycles, read only by the checks
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         strobeCyc_q <= 5'h00;
      end else begin
         strobeCyc_q <= setupPh ? 5'h01 : strobeCyc_q + {4'h0, psel};
      end
   end

   // option, pointer and flag registers; hardware set beats software clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         opt_q <= fct_pkg::OPT_RST;
         ptr_q <= 6'h00;
         alarmFlag_q <= 2'h0;
      end else begin
         if (wrOpt) opt_q <= pwdata[$bits(fct_pkg::fct_opt_t)-1:0];
         if (setPtr) ptr_q <= pwdata[5:0];
         alarmFlag_q <= (alarmFlag_q & ~{2{clrFlags}}) | alarmHitW;
      end
   end

   // digital ports; input latch follows while enabled, else holds
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         inPort_q <= 8'h00;
         dout_q <= 8'h00;
         doutOe_q <= 1'b0;
      end else begin
         inPort_q <= dinEn ? din : inPort_q;
         dout_q <= wrDio ? pwdata[7:0] : dout_q;
         doutOe_q <= opt_q.doutDrive;
      end
   end

   // interrupt gate; disable high clears and blocks everything
   wire irqRise = irqIn & ~irqIn_q & ~intDisable;
   wire irqSelOk = (opt_q.irqSel < fct_pkg::IRQ_LINES);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqIn_q <= 1'b0;
         irqPend_q <= 1'b0;
         irqLine_q <= 6'h00;
      end else begin
         irqIn_q <= irqIn;
         irqPend_q <= ~intDisable & ((irqPend_q & ~clrFlags) | irqRise);
         irqLine_q <= (irqPend_q && !intDisable && irqSelOk) ?
                      (fct_pkg::IRQ_FIRST << opt_q.irqSel) : 6'h00;
      end
   end

   // shared source and gate routing, any counter may pick any pin
   wire [7:0] gateVec = {2'b11, gatePin, 1'b1};

   genvar i;
   generate
      for (i = 0; i < fct_pkg::N_CTR; i++) begin : g_ctr
         localparam int PREV = (i + fct_pkg::N_CTR - 1) % fct_pkg::N_CTR;
         localparam bit HAS_TOD = (i < fct_pkg::N_ALARM);
         fct_pkg::fct_mode_t mode_q;
         logic [15:0] cnt_q, load_q, hold_q;
         logic armed_q, srcSmp_q, gateSmp_q, srcPrev_q;
         logic altSel_q, tc_q, out_q, outOe_q;
         logic [6:0] pre_q;

         wire wrSel = wrData && (ptrCtr == 3'(i));
         wire [7:0] srcVec = {lineHz, tcW[PREV], srcPin, tbLvl_q};
         wire srcLvl = srcVec[mode_q.srcSel] ^ mode_q.srcInv;
         wire syncEvt = opt_q.syncFall[i] ? tbFall : tbRise;
         wire srcEff = opt_q.syncEn[i] ? srcSmp_q : srcLvl;
         wire gateEff = opt_q.syncEn[i] ? gateSmp_q :
                        gateVec[mode_q.gateSel];
         wire edgeSeen = srcEff & ~srcPrev_q;
         wire todOn = HAS_TOD && mode_q.todEn;
         wire preOn = todOn && (i == 0);
         wire [6:0] preDiv =
            (mode_q.todHz == fct_pkg::TOD_HZ50) ? fct_pkg::TOD_DIV50 :
            (mode_q.todHz == fct_pkg::TOD_HZ60) ? fct_pkg::TOD_DIV60 :
            fct_pkg::TOD_DIV100;
         wire preWrap = !preOn || (pre_q == preDiv - 7'h01);
         wire live = edgeSeen & armed_q & gateEff;
         wire step = live & preWrap;
         wire [15:0] topV = !todOn ? (mode_q.bcd ? fct_pkg::BCD_MAX :
                                      fct_pkg::BIN_MAX) :
                            (i == 0) ? fct_pkg::TOD_MAX_MMSS :
                            fct_pkg::TOD_MAX_HH;
         wire goDown = mode_q.down && !todOn;
         wire atTc = goDown ? (cnt_q == 16'h0000) : (cnt_q == topV);
         wire secWrap = (cnt_q[7:0] == fct_pkg::TOD_SEC_MAX);
         wire [15:0] todIn = secWrap ?
                             {cnt_q[15:8], fct_pkg::BCD_BYTE_MAX} : cnt_q;
         wire [15:0] stepV =
            todOn ? fct_pkg::fctBcdStep(todIn, 1'b0) :
            mode_q.bcd ? fct_pkg::fctBcdStep(cnt_q, mode_q.down) :
            mode_q.down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
         wire [15:0] reloadV = (mode_q.altReload && altSel_q) ?
                               hold_q : load_q;
         wire [15:0] tcV = todOn ? 16'h0000 :
                           mode_q.reloadEn ? reloadV : stepV;

         // count, reload and terminal count path
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_q <= 16'h0000;
               altSel_q <= 1'b0;
               tc_q <= 1'b0;
            end else begin
               tc_q <= step & atTc;
               if (loadNow[i]) begin
                  cnt_q <= load_q;
                  altSel_q <= 1'b0;
               end else if (step) begin
                  cnt_q <= atTc ? tcV : stepV;
                  altSel_q <= altSel_q ^ (atTc & mode_q.altReload);
               end
            end
         end

         // host-written registers of this counter
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               mode_q <= fct_pkg::MODE_RST;
               load_q <= 16'h0000;
               hold_q <= 16'h0000;
               armed_q <= 1'b0;
            end else begin
               if (wrSel && ptrEl == fct_pkg::EL_MODE) mode_q <= pwdata[15:0];
               if (wrSel && ptrEl == fct_pkg::EL_LOAD) load_q <= pwdata[15:0];
               if (captNow[i]) begin
                  hold_q <= cnt_q;
               end else if (wrSel && ptrEl == fct_pkg::EL_HOLD) begin
                  hold_q <= pwdata[15:0];
               end
               armed_q <= (armed_q & ~armClr[i]) | armSet[i];
            end
         end

         // input sampling and output pin; sampling only on timebase edges
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               srcSmp_q <= 1'b0;
               gateSmp_q <= 1'b0;
               srcPrev_q <= 1'b0;
               pre_q <= 7'h00;
               out_q <= 1'b0;
               outOe_q <= 1'b0;
            end else begin
               if (syncEvt) srcSmp_q <= srcLvl;
               if (syncEvt) gateSmp_q <= gateVec[mode_q.gateSel];
               srcPrev_q <= srcEff;
               if (!preOn) pre_q <= 7'h00;
               else if (live) pre_q <= preWrap ? 7'h00 : pre_q + 7'h01;
               out_q <= mode_q.outEn & (out_q ^ (step & atTc));
               outOe_q <= mode_q.outEn;
            end
         end

         if (HAS_TOD) begin : g_alarm
            logic [15:0] alarm_q;
            always_ff @(posedge ref_clk or negedge rst_b) begin
               if (!rst_b) begin
                  alarm_q <= 16'h0000;
               end else if (wrSel && ptrEl == fct_pkg::EL_ALARM) begin
                  alarm_q <= pwdata[15:0];
               end
            end
            assign alarmW[i] = alarm_q;
            assign alarmHitW[i] = armed_q && (cnt_q == alarm_q);
         end else begin : g_noalarm
            assign alarmW[i] = 16'h0000;
         end

         assign cntW[i] = cnt_q;
         assign loadW[i] = load_q;
         assign holdW[i] = hold_q;
         assign modeW[i] = mode_q;
         assign tcW[i] = tc_q;
         assign armedW[i] = armed_q;
         assign outLvlW[i] = out_q;
         assign cntOut[i] = out_q;
         assign cntOutOe[i] = outOe_q;

         chk_count_up: assert property (
            step && !atTc && !mode_q.down && !mode_q.bcd && !todOn &&
            !loadNow[i] |=> cnt_q == $past(cnt_q) + 16'h0001)
            else $error("binary up count did not advance by one");
         chk_reload_tc: assert property (
            step && atTc && mode_q.reloadEn && !mode_q.altReload &&
            !todOn && !loadNow[i] |=> cnt_q == $past(load_q))
            else $error("terminal count did not reload");
         chk_capture_hold: assert property (
            captNow[i] |=> hold_q == $past(cnt_q) &&
            (cnt_q == $past(cnt_q) || $past(step) || $past(loadNow[i])))
            else $error("capture did not save the count");
         chk_out_off: assert property (
            !mode_q.outEn |=> !out_q && !outOe_q)
            else $error("disabled output still active");
      end
   endgenerate

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign dout = dout_q;
   assign doutOe = doutOe_q;
   assign irqLine = irqLine_q;

   chk_strobe_len: assert property (
      pready_q |-> strobeCyc_q ==
      (opt_q.stretch ? 5'(fct_pkg::STRETCH_CYC - 1) : 5'h02))
      else $error("ready came at the wrong strobe length");
   chk_ready_single: assert property (
      pready_q |=> !pready_q)
      else $error("ready held for more than one cycle");
   chk_decode_miss: assert property (
      accPh && !addrHit && !pready_q && waitCnt_q == 5'h00 |=>
      pslverr_q && prdata_q == 32'h0000_0000)
      else $error("unmapped access not refused");
   chk_tick_period: assert property (
      preTick |=> !preTick [*4] ##1 preTick)
      else $error("oscillator tick period wrong");
   chk_irq_block: assert property (
      intDisable |=> irqLine_q == 6'h00 && !irqPend_q)
      else $error("interrupt active while disabled");
   chk_irq_edge: assert property (
      irqRise && irqSelOk ##1 !intDisable |=> irqLine_q != 6'h00)
      else $error("rising edge did not raise interrupt");
   chk_irq_onehot: assert property (
      $onehot0(irqLine_q))
      else $error("more than one interrupt line driven");
   chk_inport_follow: assert property (
      dinEn |=> inPort_q == $past(din))
      else $error("input latch not transparent");
   chk_inport_hold: assert property (
      !dinEn |=> $stable(inPort_q))
      else $error("input latch changed while closed");
   chk_dout_hold: assert property (
      !wrDio |=> $stable(dout_q))
      else $error("output port changed without a write");

   cov_stretched: cover property (opt_q.stretch && xferEnd);
   cov_irq_raise: cover property (irqRise ##2 irqLine_q != 6'h00);
   cov_ctr_tc: cover property (tcW != 5'h00);
   cov_alarm: cover property (alarmHitW != 2'h0);
endmodule : fct_card

// File: sim/fct_host.sv
module fct_host (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle until the first transfer
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // one transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [9:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e,
         output int n);
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {a, 2'h0};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      // wait states are the card's; only the bench watchdog ends a hang
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // idle edge so the next setup never lands in this time step
      @(posedge ref_clk);
   endtask : xfer
endmodule : fct_host

// File: sim/five_counter_timer_card_tb.sv
module five_counter_timer_card_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic dinEn, irqIn, intDisable, lineHz, doutOe, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] baseSwClosed, din, dout, base, seed;
   logic [4:0] srcPin, gatePin;
   wire [4:0] cntOut, cntOutOe;
   logic [5:0] irqLine;
   logic [15:0] lv, ex;
   int n, n_fail, checks;

   fct_card fct_card_i (.ref_clk, .rst_b, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .baseSwClosed,
      .srcPin, .gatePin, .lineHz, .din, .dinEn, .irqIn, .intDisable,
      .cntOut, .cntOutOe, .dout, .doutOe, .irqLine);
   fct_host fct_host_i (.ref_clk, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);

   // 40 MHz board clock
   initial begin
      ref_clk = 1'h0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic logic [15:0] binExp(input logic [15:0] v,
         input logic dn, input int k);
      return dn ? v - 16'(k) : v + 16'(k);
   endfunction : binExp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] r, input logic [31:0] d);
      fct_host_i.xfer(1'h1, {base, r}, d, q, e, n);
   endtask : wr

   task automatic rd(input logic [1:0] r);
      fct_host_i.xfer(1'h0, {base, r}, 32'h0, q, e, n);
   endtask : rd

   // point the data register at an element of counter 0
   task automatic ptr(input logic [2:0] el);
      wr(fct_pkg::REG_CTRL, 32'h40000000 | {26'h0, el, 3'h0});
   endtask : ptr

   // slow pulses on source pin 0, wide enough for edge detection
   task automatic pulse(input int k);
      repeat (k) begin
         srcPin[0] <= 1'h1;
         repeat (3) @(posedge ref_clk);
         srcPin[0] <= 1'h0;
         repeat (3) @(posedge ref_clk);
      end
   endtask : pulse

   task automatic finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // hang guard, far beyond the fewer than a thousand cycles used
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      {rst_b, srcPin, gatePin, lineHz, din, dinEn, irqIn} = '0;
      intDisable = 1'h0;
      baseSwClosed = 8'h3F;
      base = 8'hC0;
      seed = 8'h54;
      n_fail = 0;
      checks = 0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'h1;
      @(posedge ref_clk);
      chk(irqLine, 6'h0);
      chk(cntOutOe, 5'h0);
      rd(fct_pkg::REG_OPT);
      chk(q, 32'h0);
      // random base windows, closed switch means a zero bit
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         baseSwClosed <= {1'h0, seed[6:0]};
         base = {1'h1, ~seed[6:0]};
         wr(fct_pkg::REG_DIO, {24'h0, seed});
         chk(e, 1'h0);
         rd(fct_pkg::REG_DIO);
         chk(q[7:0], seed);
         fct_host_i.xfer(1'h0, {base ^ 8'h01, 2'h2}, 32'h0, q, e, n);
         chk(q, 32'h0);
         chk(e, 1'h1);
      end
      baseSwClosed <= 8'hFF;
      fct_host_i.xfer(1'h0, 10'h002, 32'h0, q, e, n);
      chk(e, 1'h1);
      baseSwClosed <= ~base;
      wr(fct_pkg::REG_OPT, 32'h10000);
      chk(dout, seed);
      // enable flop follows the option one edge after the write lands
      @(posedge ref_clk);
      chk(doutOe, 1'h1);
      seed = lfsr(seed);
      dinEn <= 1'h1;
      din <= seed;
      @(posedge ref_clk);
      dinEn <= 1'h0;
      @(posedge ref_clk);
      din <= ~seed;
      rd(fct_pkg::REG_DIO);
      chk(q[15:8], seed);
      // strobe stretch: fifteen edges from setup to answer
      wr(fct_pkg::REG_OPT, 32'h11000);
      rd(fct_pkg::REG_OPT);
      chk(32'(n), 32'hF);
      chk(q, 32'h11000);
      wr(fct_pkg::REG_OPT, 32'h10000);
      rd(fct_pkg::REG_OPT);
      chk(32'(n), 32'h2);
      for (int k = 0; k < 6; k++) begin
         wr(fct_pkg::REG_OPT, 32'(k) << 13);
         wr(fct_pkg::REG_CTRL, 32'h80000000);
         intDisable <= 1'h1;
         irqIn <= 1'h1;
         repeat (4) @(posedge ref_clk);
         chk(irqLine, 6'h0);
         irqIn <= 1'h0;
         intDisable <= 1'h0;
         repeat (2) @(posedge ref_clk);
         irqIn <= 1'h1;
         repeat (4) @(posedge ref_clk);
         chk(irqLine, 6'h1 << k);
         irqIn <= 1'h0;
      end
      // up/down, binary/bcd; pulses with gate low must not count
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         lv = i[1] ? (i[0] ? 16'h1002 : 16'h0998) : {seed, ~seed};
         ex = i[1] ? (i[0] ? 16'h0997 : 16'h1003) : binExp(lv, i[0], 5);
         gatePin[0] <= 1'h0;
         ptr(fct_pkg::EL_MODE);
         wr(fct_pkg::REG_DATA, {20'h0, 2'h2, i[1], i[0], 8'h21});
         ptr(fct_pkg::EL_LOAD);
         wr(fct_pkg::REG_DATA, {16'h0, lv});
         wr(fct_pkg::REG_CTRL, 32'h00800100);
         pulse(2);
         gatePin[0] <= 1'h1;
         pulse(5);
         wr(fct_pkg::REG_CTRL, 32'h00040000);
         ptr(fct_pkg::EL_HOLD);
         rd(fct_pkg::REG_DATA);
         chk(q, {16'h0, ex});
         ptr(fct_pkg::EL_COUNT);
         rd(fct_pkg::REG_DATA);
         chk(q, {16'h0, ex});
         chk(cntOutOe, 5'h1);
      end
      // outEn low clears the pin; then reload at terminal count toggles it
      ptr(fct_pkg::EL_MODE);
      wr(fct_pkg::REG_DATA, 32'h0);
      @(posedge ref_clk);
      chk(cntOut, 5'h0);
      chk(cntOutOe, 5'h0);
      wr(fct_pkg::REG_DATA, 32'h8921);
      ptr(fct_pkg::EL_LOAD);
      wr(fct_pkg::REG_DATA, 32'h2);
      wr(fct_pkg::REG_CTRL, 32'h00800000);
      pulse(3);
      chk(cntOut, 5'h1);
      ptr(fct_pkg::EL_COUNT);
      rd(fct_pkg::REG_DATA);
      chk(q, 32'h2);
      // alarm match sets the flag; stale flags cleared first
      ptr(fct_pkg::EL_ALARM);
      wr(fct_pkg::REG_DATA, 32'h1);
      wr(fct_pkg::REG_CTRL, 32'h80000000);
      pulse(1);
      rd(fct_pkg::REG_CTRL);
      chk(q[25:24], 2'h1);
      chk(q[12:8], 5'h01);
      // time of day: fifty source pin 0 pulses per second, 00:59 rolls to 01:00
      ptr(fct_pkg::EL_MODE);
      wr(fct_pkg::REG_DATA, 32'h1821);
      ptr(fct_pkg::EL_LOAD);
      wr(fct_pkg::REG_DATA, 32'h59);
      wr(fct_pkg::REG_CTRL, 32'h00800000);
      pulse(49);
      ptr(fct_pkg::EL_COUNT);
      rd(fct_pkg::REG_DATA);
      chk(q, 32'h59);
      pulse(1);
      rd(fct_pkg::REG_DATA);
      chk(q, 32'h100);
      finish_test();
   end
endmodule : five_counter_timer_card_tb
